/* File: hdl/idxp_display.sv */
`default_nettype none
// Three-character status display, decoded from the display state
module idxp_display (
    input wire idxp_pkg::idxp_disp_state_type state,
    input wire logic [7:0] station_no,
    input wire logic test_mode,
    input wire logic [7:0] exec_station,
    input wire logic show_code,
    input wire logic [7:0] code,
    input wire logic cpu_error,
    input wire logic flicker_dp,
    output idxp_pkg::idxp_display_type disp
);
    import idxp_pkg::*;
    function automatic logic [11:0] idxp_bcd(input logic [7:0] v);
        logic [7:0] h;
        logic [7:0] t;
        logic [7:0] o;
        h = v / 8'd100;
        t = (v % 8'd100) / 8'd10;
        o = v % 8'd10;
        return {h[3:0], t[3:0], o[3:0]};
    endfunction : idxp_bcd
    logic [11:0] st_bcd;
    logic [11:0] ex_bcd;
    logic [4:0] hi;
    logic [4:0] lo;
    always_comb begin
        st_bcd = idxp_bcd(station_no);
        ex_bcd = idxp_bcd(exec_station);
        // Test mode replaces the station field with 00
        hi = test_mode ? 5'h00 : {1'b0, st_bcd[7:4]};
        lo = test_mode ? 5'h00 : {1'b0, st_bcd[3:0]};
        disp = '{ch2: CH_BLANK, ch1: CH_BLANK, ch0: CH_BLANK, dp: 3'b000};
        if (cpu_error) begin
            disp = '{ch2: CH_EIGHT, ch1: CH_EIGHT, ch0: CH_EIGHT,
                     dp: 3'b111};
        end else if (show_code) begin
            disp.ch2 = CH_A;
            disp.ch1 = {1'b0, code[7:4]};
            disp.ch0 = {1'b0, code[3:0]};
            disp.dp[1] = flicker_dp;
        end else begin
            case (state)
                DS_WAIT: begin
                    disp.ch2 = CH_B;
                    disp.ch1 = hi;
                    disp.ch0 = lo;
                end
                DS_NOT_READY: begin
                    disp.ch2 = CH_C;
                    disp.ch1 = hi;
                    disp.ch0 = lo;
                end
                DS_READY: begin
                    disp.ch2 = CH_D;
                    disp.ch1 = hi;
                    disp.ch0 = lo;
                end
                DS_RUN: begin
                    disp.ch2 = {1'b0, ex_bcd[11:8]};
                    disp.ch1 = {1'b0, ex_bcd[7:4]};
                    disp.ch0 = {1'b0, ex_bcd[3:0]};
                end
                default: begin
                    disp.ch2 = CH_BLANK;
                end
            endcase
            disp.dp[0] = test_mode && (state != DS_RUN);
        end
    end
endmodule : idxp_display
`default_nettype wire

/* File: hdl/idxp_path.sv */
`default_nettype none
// Direction and distance from the current to the selected station
module idxp_path (
    input wire logic [7:0] current,
    input wire logic [7:0] target,
    input wire logic [8:0] count,
    input wire logic shortest,
    input wire logic forward_req,
    input wire logic dir_param,
    output logic cw,
    output logic [7:0] distance
);
    import idxp_pkg::*;
    logic [8:0] fwd;
    logic [8:0] bwd;
    logic forward;
    always_comb begin
        fwd = (target >= current) ? 9'(target - current)
                                  : 9'(count - 9'(current - target));
        bwd = (current >= target) ? 9'(current - target)
                                  : 9'(count - 9'(target - current));
        // Shortest picks the nearer way, ties go forward
        forward = shortest ? (fwd <= bwd) : forward_req;
        // Forward means rising station numbers; the parameter mirrors it
        cw = forward ^ dir_param;
        distance = forward ? fwd[7:0] : bwd[7:0];
    end
endmodule : idxp_path
`default_nettype wire

/* File: hdl/idxp_pkg.sv */
`default_nettype none
package idxp_pkg;
    // Clock and display timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned READY_HOLD_MS = 2000;
    localparam int unsigned READY_HOLD_CYCLES = CLK_HZ / 1000 * READY_HOLD_MS;
    localparam int unsigned FLICKER_MS = 250;
    localparam int unsigned FLICKER_CYCLES = CLK_HZ / 1000 * FLICKER_MS;
    localparam int unsigned CNT_W = 26;
    ////////////////////////////////////////////////////////////////////////
    // Parameter decoding
    localparam int unsigned CTRL_DIGIT_LSB = 12;
    localparam logic [3:0] INDEXER_DIGIT = 4'h1;
    localparam logic [15:0] STATION_PARAM_MIN = 16'h0002;
    localparam logic [15:0] STATION_PARAM_MAX = 16'h00FF;
    localparam logic [8:0] STATION_COUNT_MIN = 9'h002;
    localparam logic [8:0] STATION_COUNT_MAX = 9'h0FF;
    // Speeds are in units of 0.1 r/min
    localparam logic [19:0] RATED_SPEED_X10 = 20'h0_7530;
    localparam logic [15:0] CMX_THRESHOLD = 16'h07D0;
    localparam logic [19:0] SPEED_LIMIT_LOW_X10 = 20'h0_782F;
    localparam logic [19:0] SPEED_LIMIT_BASE_X10 = 20'h0_7FFF;
    localparam logic [3:0] CMX_SCALE = 4'hA;
    ////////////////////////////////////////////////////////////////////////
    // Codes shown after the alarm prefix
    localparam logic [7:0] CODE_FORCED_STOP = 8'hE6;
    localparam logic [7:0] CODE_ABS_COUNTER = 8'hE3;
    localparam logic [7:0] CODE_NEXT_STATION = 8'h97;
    localparam logic [7:0] CODE_HOME_INCOMPLETE = 8'h90;
    // Character codes: 0x00..0x0F are hex digits, A doubles as prefix
    localparam logic [4:0] CH_A = 5'h0A;
    localparam logic [4:0] CH_B = 5'h10;
    localparam logic [4:0] CH_C = 5'h11;
    localparam logic [4:0] CH_D = 5'h12;
    localparam logic [4:0] CH_EIGHT = 5'h08;
    localparam logic [4:0] CH_BLANK = 5'h13;
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        MV_IDLE = 2'b01,
        MV_BUSY = 2'b10
    } idxp_motion_type;
    typedef enum logic [3:0] {
        DS_WAIT = 4'b0001,
        DS_NOT_READY = 4'b0010,
        DS_READY = 4'b0100,
        DS_RUN = 4'b1000
    } idxp_disp_state_type;
    typedef struct packed {
        logic [15:0] speed;
        logic [15:0] acc_ms;
        logic [15:0] dec_ms;
    } idxp_point_type;
    typedef idxp_point_type [7:0] idxp_point_table_type;
    typedef struct packed {
        logic [4:0] ch2;
        logic [4:0] ch1;
        logic [4:0] ch0;
        logic [2:0] dp;
    } idxp_display_type;
    typedef struct packed {
        logic start;
        logic cw;
        logic [7:0] target;
        logic [7:0] distance;
        idxp_point_type profile;
    } idxp_move_type;
    typedef struct packed {
        idxp_motion_type mv;
        idxp_disp_state_type disp;
        logic start_q;
        logic [7:0] target;
        logic [2:0] speed_sel;
        logic [7:0] current;
        logic complete;
        logic home_alarm;
        logic station_warn;
        logic abs_warn;
        logic [CNT_W-1:0] hold_cnt;
        logic [CNT_W-1:0] flick_cnt;
        logic flick;
        idxp_display_type display;
        idxp_move_type move;
    } idxp_state_type;
endpackage : idxp_pkg
`default_nettype wire

/* File: hdl/idxp_top.sv */
// Function
// - After init with servo on, show ready letter and station for 2 s.
// - While initializing or with servo off, show not-ready letter and station; under alarm the code display wins.
// - Two seconds after ready, show executing station 0 to 254.
// - Alarm or warning shows prefix plus its code, no station.
// - Watchdog error lights every segment of all three digits.
// - Station field 00 means test mode, 01 to 64 the station.
// - Non forced-stop warning with servo on flickers the middle point.
// - Absolute mode speed at or above gear-dependent limit raises counter warning.
// - Up to 255 stations; target taken from eight select bits.
// - Station count comes from the station-count parameter.
// - Two methods: fixed direction, or shortest path chosen automatically.
// - Mode 1 always turns in the fixed direction.
// - Mode 1 speed and ramp times come from the point table.
// - Indexer needs top control digit 1 and mode bits off/on (mode 1) or on/on (shortest).
// - Direction parameter 0 numbers stations clockwise, 1 counter-clockwise.
// - Ramp times are referenced to the 3000 r/min rated speed.
// - Station beyond count minus one raises the next-station warning.
// - Start is ignored while moving; master waits for completion.
// - Start before homing raises home-incomplete alarm, no move.
`default_nettype none
module idxp_top #(
    parameter int unsigned READY_HOLD_COUNT = idxp_pkg::READY_HOLD_CYCLES,
    parameter int unsigned FLICKER_COUNT = idxp_pkg::FLICKER_CYCLES
) (
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic SERVO_ON_REQUEST_BIT,
    input wire logic START_REQUEST_BIT,
    input wire logic OPERATION_MODE_SELECT_ONE,
    input wire logic OPERATION_MODE_SELECT_TWO,
    input wire logic ROTATION_DIRECTION_BIT,
    input wire logic [7:0] NEXT_STATION_SELECT_BITS,
    input wire logic [2:0] SPEED_SELECT_BITS,
    input wire logic [15:0] CONTROL_MODE_PARAMETER,
    input wire logic [15:0] STATION_COUNT_PARAMETER,
    input wire logic STATION_DIRECTION_PARAMETER,
    input wire logic [15:0] GEAR_NUMERATOR_PARAMETER,
    input wire logic ABS_DETECT_ENABLE,
    input wire logic [15:0] MOTOR_SPEED_X10,
    input wire idxp_pkg::idxp_point_table_type POINT_TABLE,
    input wire logic MOTION_DONE,
    input wire logic INIT_DONE,
    input wire logic HOME_DONE,
    input wire logic COMM_ESTABLISHED,
    input wire logic [7:0] STATION_NUMBER,
    input wire logic TEST_MODE,
    input wire logic ALARM_ACTIVE,
    input wire logic [7:0] ALARM_CODE,
    input wire logic WARNING_ACTIVE,
    input wire logic [7:0] WARNING_CODE,
    input wire logic WATCHDOG_ERROR,
    output idxp_pkg::idxp_display_type DISPLAY,
    output idxp_pkg::idxp_move_type MOVE_CMD,
    output logic MOVEMENT_COMPLETE_OUTPUT,
    output logic [7:0] CURRENT_STATION,
    output logic HOME_INCOMPLETE_ALARM,
    output logic NEXT_STATION_WARNING,
    output logic ABS_COUNTER_WARNING
);
    import idxp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    idxp_state_type st;
    idxp_state_type next_st;
    idxp_display_type disp_out;
    logic start_rise;
    logic servo_ready;
    logic indexer_on;
    logic mode_one;
    logic mode_short;
    logic start_ok;
    logic accept_move;
    logic [8:0] count;
    logic [8:0] limit;
    logic [19:0] speed_limit;
    logic path_cw;
    logic [7:0] path_dist;
    logic show_code;
    logic [7:0] code;
    logic own_warn;
    logic flicker_dp;
    logic [CNT_W-1:0] hold_last;
    logic [CNT_W-1:0] flick_last;

    ////////////////////////////////////////////////////////////////////////
    // Combinational decoding of parameters and requests
    always_comb begin
        hold_last = CNT_W'(READY_HOLD_COUNT - 1);
        flick_last = CNT_W'(FLICKER_COUNT - 1);
        start_rise = START_REQUEST_BIT && !st.start_q;
        servo_ready = INIT_DONE && SERVO_ON_REQUEST_BIT && !ALARM_ACTIVE;
        indexer_on = CONTROL_MODE_PARAMETER[CTRL_DIGIT_LSB +: 4]
                     == INDEXER_DIGIT;
        mode_one = !OPERATION_MODE_SELECT_ONE
                   && OPERATION_MODE_SELECT_TWO;
        mode_short = OPERATION_MODE_SELECT_ONE && OPERATION_MODE_SELECT_TWO;
        // Settings below two still give two stations, above 255 saturate
        if (STATION_COUNT_PARAMETER <= STATION_PARAM_MIN) begin
            count = STATION_COUNT_MIN;
        end else if (STATION_COUNT_PARAMETER >= STATION_PARAM_MAX) begin
            count = STATION_COUNT_MAX;
        end else begin
            count = STATION_COUNT_PARAMETER[8:0];
        end
        limit = count - 9'h001;
        // Above the gear threshold the limit shrinks; below zero it wraps to a large unsigned value
        if (GEAR_NUMERATOR_PARAMETER <= CMX_THRESHOLD) begin
            speed_limit = SPEED_LIMIT_LOW_X10;
        end else begin
            speed_limit = SPEED_LIMIT_BASE_X10
                - 20'(GEAR_NUMERATOR_PARAMETER) * 20'(CMX_SCALE);
        end
        start_ok = start_rise && (st.mv == MV_IDLE) && indexer_on
                   && (mode_one || mode_short) && servo_ready;
        accept_move = start_ok && HOME_DONE
                      && ({1'b0, NEXT_STATION_SELECT_BITS} <= limit);
        own_warn = st.home_alarm || st.abs_warn || st.station_warn;
        show_code = ALARM_ACTIVE || WARNING_ACTIVE || own_warn;
        if (ALARM_ACTIVE) begin
            code = ALARM_CODE;
        end else if (WARNING_ACTIVE) begin
            code = WARNING_CODE;
        end else if (st.home_alarm) begin
            code = CODE_HOME_INCOMPLETE;
        end else if (st.abs_warn) begin
            code = CODE_ABS_COUNTER;
        end else begin
            code = CODE_NEXT_STATION;
        end
        flicker_dp = SERVO_ON_REQUEST_BIT && !ALARM_ACTIVE && show_code
                     && (code != CODE_FORCED_STOP) && st.flick;
    end

    ////////////////////////////////////////////////////////////////////////
    idxp_path u_path (
        .current(st.current),
        .target(NEXT_STATION_SELECT_BITS),
        .count(count),
        .shortest(mode_short),
        .forward_req(ROTATION_DIRECTION_BIT),
        .dir_param(STATION_DIRECTION_PARAMETER),
        .cw(path_cw),
        .distance(path_dist)
    );

    idxp_display u_display (
        .state(st.disp),
        .station_no(STATION_NUMBER),
        .test_mode(TEST_MODE),
        .exec_station(st.current),
        .show_code(show_code),
        .code(code),
        .cpu_error(WATCHDOG_ERROR),
        .flicker_dp(flicker_dp),
        .disp(disp_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_st = st;
        next_st.start_q = START_REQUEST_BIT;
        next_st.move.start = 1'b0;
        next_st.display = disp_out;
        next_st.station_warn = indexer_on
            && ({1'b0, NEXT_STATION_SELECT_BITS} > limit);
        next_st.abs_warn = ABS_DETECT_ENABLE
            && ({4'h0, MOTOR_SPEED_X10} >= speed_limit);
        // Cleared only by homing, which also removes the cause
        if (HOME_DONE) begin
            next_st.home_alarm = 1'b0;
        end
        case (st.mv)
            MV_IDLE: begin
                if (start_ok && !HOME_DONE) begin
                    next_st.home_alarm = 1'b1;
                end else if (accept_move) begin
                    // Selects sampled once here, later changes ignored
                    next_st.target = NEXT_STATION_SELECT_BITS;
                    next_st.speed_sel = SPEED_SELECT_BITS;
                    next_st.move.start = 1'b1;
                    next_st.move.target = NEXT_STATION_SELECT_BITS;
                    next_st.move.cw = path_cw;
                    next_st.move.distance = path_dist;
                    // Ramp times are per 0..rated speed, passed unscaled
                    next_st.move.profile =
                        POINT_TABLE[SPEED_SELECT_BITS];
                    next_st.complete = 1'b0;
                    next_st.mv = MV_BUSY;
                end
            end
            MV_BUSY: begin
                // Start edges here fall through: no branch consumes them
                if (!servo_ready) begin
                    next_st.mv = MV_IDLE;
                end else if (MOTION_DONE) begin
                    next_st.current = st.target;
                    next_st.complete = 1'b1;
                    next_st.mv = MV_IDLE;
                end
            end
            default: begin
                next_st.mv = MV_IDLE;
            end
        endcase
        case (st.disp)
            DS_WAIT: begin
                next_st.disp = DS_NOT_READY;
            end
            DS_NOT_READY: begin
                if (servo_ready) begin
                    next_st.disp = DS_READY;
                    next_st.hold_cnt = '0;
                end
            end
            DS_READY: begin
                if (!servo_ready) begin
                    next_st.disp = DS_NOT_READY;
                end else if (st.hold_cnt >= hold_last) begin
                    next_st.disp = DS_RUN;
                end else begin
                    next_st.hold_cnt = st.hold_cnt + CNT_W'(1);
                end
            end
            DS_RUN: begin
                if (!servo_ready) begin
                    next_st.disp = DS_NOT_READY;
                end
            end
            default: begin
                next_st.disp = DS_WAIT;
            end
        endcase
        if (!COMM_ESTABLISHED) begin
            next_st.disp = DS_WAIT;
        end
        if (st.flick_cnt >= flick_last) begin
            next_st.flick_cnt = '0;
            next_st.flick = !st.flick;
        end else begin
            next_st.flick_cnt = st.flick_cnt + CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            next_st_reset();
        end else begin
            st <= next_st;
        end
    end

    task automatic next_st_reset();
        st <= '0;
        st.mv <= MV_IDLE;
        st.disp <= DS_WAIT;
        st.complete <= 1'b1;
        st.display <= '{ch2: CH_BLANK, ch1: CH_BLANK, ch0: CH_BLANK,
                        dp: 3'b000};
    endtask : next_st_reset

    assign DISPLAY = st.display;
    assign MOVE_CMD = st.move;
    assign MOVEMENT_COMPLETE_OUTPUT = st.complete;
    assign CURRENT_STATION = st.current;
    assign HOME_INCOMPLETE_ALARM = st.home_alarm;
    assign NEXT_STATION_WARNING = st.station_warn;
    assign ABS_COUNTER_WARNING = st.abs_warn;

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_B);

    a_start_busy_ignored: assert property (
        (st.mv == MV_BUSY) && start_rise |=> !st.move.start
    ) else $error("start accepted while moving");

    a_home_alarm_raise: assert property (
        start_ok && !HOME_DONE |=> st.home_alarm && !st.move.start
            && (st.mv == MV_IDLE)
    ) else $error("start without homing did not alarm");

    a_station_warn_set: assert property (
        indexer_on && ({1'b0, NEXT_STATION_SELECT_BITS} > limit)
            |=> st.station_warn
    ) else $error("out of range station not flagged");

    a_select_latched: assert property (
        accept_move |=> st.move.start
            && (st.move.target == $past(NEXT_STATION_SELECT_BITS))
            && (st.speed_sel == $past(SPEED_SELECT_BITS))
            && (st.move.profile == $past(POINT_TABLE[SPEED_SELECT_BITS]))
    ) else $error("selects not latched on start");

    a_fixed_direction: assert property (
        accept_move && mode_one |=> st.move.cw ==
            ($past(ROTATION_DIRECTION_BIT)
             ^ $past(STATION_DIRECTION_PARAMETER))
    ) else $error("fixed mode direction wrong");

    a_ready_to_run: assert property (
        (st.disp == DS_READY) && (st.hold_cnt >= hold_last)
            && servo_ready && COMM_ESTABLISHED |=> (st.disp == DS_RUN)
    ) else $error("ready hold did not end");

    a_ready_letter: assert property (
        (st.disp == DS_READY) && !WATCHDOG_ERROR && !show_code
            |=> (st.display.ch2 == CH_D)
    ) else $error("ready letter missing");

    a_cpu_all_lit: assert property (
        WATCHDOG_ERROR |=> (st.display.ch2 == CH_EIGHT)
            && (st.display.ch1 == CH_EIGHT) && (st.display.dp == 3'b111)
    ) else $error("cpu error not shown");

    a_abs_limit_low: assert property (
        ABS_DETECT_ENABLE && (GEAR_NUMERATOR_PARAMETER <= CMX_THRESHOLD)
            && ({4'h0, MOTOR_SPEED_X10} >= SPEED_LIMIT_LOW_X10)
            |=> st.abs_warn
    ) else $error("speed limit warning missing");

    a_done_completes: assert property (
        (st.mv == MV_BUSY) && servo_ready && MOTION_DONE
            |=> st.complete && (st.current == $past(st.target))
    ) else $error("move completion not reported");

    a_test_field_zero: assert property (
        TEST_MODE && !WATCHDOG_ERROR && !show_code && (st.disp != DS_RUN)
            |=> (st.display.ch1 == 5'h00) && (st.display.ch0 == 5'h00)
            && st.display.dp[0]
    ) else $error("test mode field not shown");

    a_far_station_idle: assert property (
        start_ok && ({1'b0, NEXT_STATION_SELECT_BITS} > limit)
            |=> !st.move.start && (st.mv == MV_IDLE)
    ) else $error("out of range station started a move");

    a_code_prefix: assert property (
        show_code && !WATCHDOG_ERROR |=> (st.display.ch2 == CH_A)
    ) else $error("alarm prefix missing");
endmodule : idxp_top
`default_nettype wire

/* File: sim/idxp_master_model.sv */
`default_nettype none
// Fieldbus master: sets the selects and pulses start for one cycle
module idxp_master_model (
    input wire logic clk,
    input wire logic go,
    input wire logic hurry,
    input wire logic [7:0] station,
    input wire logic [2:0] speed,
    input wire logic complete,
    output logic start,
    output logic mode_one,
    output logic mode_two,
    output logic [7:0] station_sel,
    output logic [2:0] speed_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        start = 1'b0;
        mode_one = 1'b0;
        mode_two = 1'b1;
        station_sel = 8'h00;
        speed_sel = 3'h0;
    end
    // Hurry breaks the wait for completion, only when a test asks
    always @(posedge clk) begin
        start <= #2 go && (complete || hurry) && !start;
        if (go && !start) begin
            station_sel <= #2 station;
            speed_sel <= #2 speed;
        end
    end
endmodule : idxp_master_model
`default_nettype wire

/* File: sim/testbench.sv */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import idxp_pkg::*;
    logic clk, rst_b, servo, go, hurry, done, init, home, comm, alarm;
    logic warn, wdog, absen, start, m1, m2, cmpl, halarm, swarn, awarn;
    logic rdir, sdir, tmode;
    logic [7:0] st, stsel, cur;
    logic [2:0] sp, spsel;
    logic [15:0] ctrl, cnt, gear, spd;
    idxp_point_table_type pt;
    idxp_display_type disp;
    idxp_move_type mv;
    int errors, total_checks;
    idxp_top #(.READY_HOLD_COUNT(20), .FLICKER_COUNT(4)) idxp_top_i (
        .REF_CLK(clk), .RST_B(rst_b), .SERVO_ON_REQUEST_BIT(servo),
        .START_REQUEST_BIT(start), .OPERATION_MODE_SELECT_ONE(m1),
        .OPERATION_MODE_SELECT_TWO(m2), .ROTATION_DIRECTION_BIT(rdir),
        .NEXT_STATION_SELECT_BITS(stsel), .SPEED_SELECT_BITS(spsel),
        .CONTROL_MODE_PARAMETER(ctrl), .STATION_COUNT_PARAMETER(cnt),
        .STATION_DIRECTION_PARAMETER(sdir), .GEAR_NUMERATOR_PARAMETER(gear),
        .ABS_DETECT_ENABLE(absen), .MOTOR_SPEED_X10(spd), .POINT_TABLE(pt),
        .MOTION_DONE(done), .INIT_DONE(init), .HOME_DONE(home),
        .COMM_ESTABLISHED(comm), .STATION_NUMBER(8'h01), .TEST_MODE(tmode),
        .ALARM_ACTIVE(alarm), .ALARM_CODE(8'h55), .WARNING_ACTIVE(warn),
        .WARNING_CODE(8'h12), .WATCHDOG_ERROR(wdog), .DISPLAY(disp),
        .MOVE_CMD(mv), .MOVEMENT_COMPLETE_OUTPUT(cmpl),
        .CURRENT_STATION(cur), .HOME_INCOMPLETE_ALARM(halarm),
        .NEXT_STATION_WARNING(swarn), .ABS_COUNTER_WARNING(awarn));
    idxp_master_model idxp_master_model_i (.clk(clk), .go(go),
        .hurry(hurry), .station(st), .speed(sp), .complete(cmpl),
        .start(start), .mode_one(m1), .mode_two(m2), .station_sel(stsel),
        .speed_sel(spsel));
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    task automatic chk_val(input logic [19:0] got, input logic [19:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({19'h0_0000, got}, {19'h0_0000, exp});
    endtask : chk_bit
    task automatic chk_disp(input logic [14:0] exp);
        chk_val(20'({disp.ch2, disp.ch1, disp.ch0}), 20'(exp));
    endtask : chk_disp
    // Returns just after the edge at which the start request is taken
    task automatic launch(input logic [7:0] s, input logic [2:0] p);
        tick(1);
        st = s;
        sp = p;
        go = 1'b1;
        tick(2);
        go = 1'b0;
    endtask : launch
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////
    task automatic t_display;
        {comm, tmode} = 2'h3;
        tick(3);
        chk_disp({CH_C, 10'h000});
        chk_bit(disp.dp[0], 1'b1);
        tmode = 1'b0;
        tick(1);
        chk_disp({CH_C, 10'h001});
        {init, servo} = 2'b11;
        tick(12);
        chk_disp({CH_D, 10'h001});
        tick(12);
        chk_disp(15'h0000);
        $display("display test done");
    endtask : t_display
    task automatic t_home;
        launch(8'h01, 3'h0);
        chk_bit(halarm, 1'b1);
        chk_bit(cmpl, 1'b1);
        tick(2);
        chk_disp({CH_A, 10'h120});
        home = 1'b1;
        tick(3);
        chk_bit(halarm, 1'b0);
        $display("home test done");
    endtask : t_home
    task automatic t_move;
        launch(8'h04, 3'h0);
        chk_bit(swarn, 1'b1);
        chk_bit(mv.start, 1'b0);
        launch(8'h03, 3'h1);
        chk_bit(swarn, 1'b0);
        chk_bit(mv.start, 1'b1);
        chk_val(20'(mv.target), 20'h0_0003);
        chk_bit(mv.cw, 1'b1);
        chk_val(20'(mv.distance), 20'h0_0003);
        chk_bit(mv.profile === pt[1], 1'b1);
        hurry = 1'b1;
        launch(8'h05, 3'h2);
        hurry = 1'b0;
        chk_val(20'(mv.target), 20'h0_0003);
        chk_bit(cmpl, 1'b0);
        done = 1'b1;
        tick(1);
        done = 1'b0;
        tick(1);
        chk_bit(cmpl, 1'b1);
        chk_val(20'(cur), 20'h0_0003);
        tick(2);
        chk_disp({CH_A, 10'h127});
        // Backward under mirrored numbering still turns clockwise
        {rdir, sdir} = 2'h1;
        launch(8'h01, 3'h2);
        chk_bit(mv.start, 1'b1);
        chk_bit(mv.cw, 1'b1);
        chk_val(20'(mv.distance), 20'h0_0002);
        $display("move test done");
    endtask : t_move
    task automatic t_flicker;
        logic a;
        warn = 1'b1;
        tick(3);
        a = disp.dp[1];
        tick(4);
        chk_bit(disp.dp[1], ~a);
        warn = 1'b0;
        alarm = 1'b1;
        tick(2);
        chk_disp({CH_A, 10'h0A5});
        chk_bit(disp.dp[1], 1'b0);
        alarm = 1'b0;
        $display("flicker test done");
    endtask : t_flicker
    task automatic t_abs(input logic [15:0] g, input logic [15:0] s,
            input logic exp);
        absen = 1'b1;
        gear = g;
        spd = s;
        tick(3);
        chk_bit(awarn, exp);
        $display("absolute speed test done");
    endtask : t_abs
    task automatic t_wdog;
        wdog = 1'b1;
        tick(3);
        chk_disp({3{CH_EIGHT}});
        chk_val(20'(disp.dp), 20'h0_0007);
        $display("watchdog test done");
    endtask : t_wdog
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Whole run is under 200 cycles
    initial begin
        #100_000;
        errors++;
        conclude();
    end
    initial begin
        {servo, go, hurry, done, init, home, comm} = 7'h00;
        {rdir, sdir, tmode} = 3'h4;
        {alarm, warn, wdog, absen, rst_b} = 5'h00;
        {st, sp, errors, total_checks} = '0;
        {ctrl, cnt, gear, spd} = {16'h1000, 16'h0004, 16'h0000, 16'h0000};
        for (int i = 0; i < 8; i++) begin
            pt[i] = {16'(i) + 16'h0100, 16'(i) + 16'h0200,
                     16'(i) + 16'h0300};
        end
        tick(6);
        rst_b = 1'b1;
        t_display();
        t_home();
        t_move();
        t_flicker();
        t_abs(16'h07D0, 16'h782F, 1'b1);
        t_abs(16'h07D0, 16'h782E, 1'b0);
        t_abs(16'h07D1, 16'h31D5, 1'b1);
        t_abs(16'h07D1, 16'h31D4, 1'b0);
        t_wdog();
        conclude();
    end
endmodule : testbench
`default_nettype wire
